// ==== core/afc_pkg.sv ====
// Purpose: Constants for the receive flow control configuration block
// Assumes: 200 MHz system clock, APB register access
// Notes: Shared by the top module and the jam timer
//
// How it works
// [RULE1] Data register holds 32-bit value moved to or from internal MAC registers.
// [RULE2] Writing busy bit starts MAC register transfer; stays set until done.
// [RULE3] No pause frames or jamming while the transmitter is disabled.
// [RULE4] High threshold in 64-byte units sets trigger level; trigger bits pick action.
// [RULE5] Full duplex: reaching high threshold sends exactly one pause frame.
// [RULE6] Half duplex: jam matching frames for programmed duration after threshold.
// [RULE7] Falling below low threshold sends a zero-time pause frame.
// [RULE8] Zero-time pause only after high reached and a pause was sent.
// [RULE9] Software keeps low threshold strictly below high threshold.
// [RULE10] Four-bit duration code sets jam length; ignored in full duplex.
// [RULE11] Duration codes map 5,10,15,25,50..600 us; 10 Mb/s adds 2.2 us.
// [RULE12] Multicast trigger bit jams multicast frames after threshold, half duplex.
// [RULE13] Broadcast trigger bit jams broadcast frames after threshold, half duplex.
// [RULE14] Own-address trigger bit jams own-address frames after threshold, half duplex.
// [RULE15] Any-frame bit overrides others; preamble in half, pause in full duplex.
// [RULE16] Occupancy in bytes compared to threshold times 64; state held till low.
package afc_pkg;
	localparam logic [7:0] DATA_ADDR = 8'hA8;
	localparam logic [7:0] CMD_ADDR = 8'hA4;
	localparam logic [7:0] CFG_ADDR = 8'hAC;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] CMD_RESET = 32'h0000_0000;
	localparam int CMD_BUSY_BIT = 31;
	localparam int CMD_READ_BIT = 30;
	localparam int HI_LSB = 16;
	localparam int LO_LSB = 8;
	localparam int DUR_LSB = 4;
	localparam int MULT_BIT = 3;
	localparam int BRD_BIT = 2;
	localparam int ADD_BIT = 1;
	localparam int ANY_BIT = 0;
	localparam logic [31:0] CFG_WR_MASK = 32'h00FF_FFFF;
	localparam logic [31:0] CMD_WR_MASK = 32'h4000_00FF;
	localparam int UNIT_SHIFT = 6;
	localparam int FIFO_W = 15;
	localparam int CLK_MHZ = 200;
	localparam int STEP_NS = 100;
	localparam int EXTRA_10M_NS = 2200;
	localparam int CNT_W = 18;
	localparam logic [CNT_W-1:0] CYC_PER_STEP = CNT_W'(STEP_NS * CLK_MHZ / 1000);
	localparam logic [CNT_W-1:0] EXTRA_10M_CYC = CNT_W'(EXTRA_10M_NS * CLK_MHZ / 1000);
	typedef enum {IDLE_S, XFER_S} xfer_state_type;
endpackage

// ==== core/jam_timer.sv ====
// Purpose: Times one back-pressure interval from the duration code
// Assumes: Start is a one-cycle pulse; restart while running reloads
// Notes: One 18-bit counter counts clock cycles directly; there is no 100 ns step counter
`timescale 1ns/10ps
`default_nettype none
module jam_timer (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic [3:0] code_in,
	input wire logic slow_in,
	output logic busy_out
);
	import afc_pkg::*;

	logic [CNT_W-1:0] left_q, left_d;
	logic busy_q, busy_d;

	// Length in 100 ns steps for the code, at 100 Mb/s
	function automatic logic [CNT_W-1:0] steps(input logic [3:0] code);
		logic [CNT_W-1:0] r;
		r = '0;
		case (code)
			4'h0: r = CNT_W'(50);
			4'h1: r = CNT_W'(100);
			4'h2: r = CNT_W'(150);
			4'h3: r = CNT_W'(250);
			default: r = CNT_W'((32'(code) - 32'd3) * 32'd500);
		endcase
		return r;
	endfunction

	always_comb begin
		left_d = left_q;
		busy_d = busy_q;
		if (start_in) begin
			// Cycle count of the mapped duration; 10 Mb/s adds a fixed tail [RULE11]
			left_d = CNT_W'(steps(code_in) * CYC_PER_STEP) + (slow_in ? EXTRA_10M_CYC : '0);
			busy_d = 1'b1;
		end else if (busy_q) begin
			if (left_q <= CNT_W'(1)) begin
				busy_d = 1'b0;
				left_d = '0;
			end else begin
				left_d = left_q - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			left_q <= '0;
			busy_q <= 1'b0;
		end else begin
			left_q <= left_d;
			busy_q <= busy_d;
		end
	end

	assign busy_out = busy_q;
endmodule
`default_nettype wire

// ==== core/rx_flow_ctrl.sv ====
// Purpose: Receive flow control configuration and engine with MAC register transfer port
// Assumes: Frame status and FIFO level come from logic on the same clock
// Notes: APB slave, zero wait states; internal MAC register side is a req/ack handshake
`timescale 1ns/10ps
`default_nettype none
module rx_flow_ctrl (
	// Clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	// APB
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Internal MAC register port
	output logic MAC_REQ_OUT,
	output logic MAC_READ_OUT,
	output logic [7:0] MAC_ADDR_OUT,
	output logic [31:0] MAC_WDATA_OUT,
	input wire logic MAC_ACK_IN,
	input wire logic [31:0] MAC_RDATA_IN,
	// MAC status
	input wire logic TX_ENABLED_IN,
	input wire logic FULL_DUPLEX_IN,
	input wire logic SPEED_10_IN,
	input wire logic [afc_pkg::FIFO_W-1:0] RX_FIFO_BYTES_IN,
	// Receive frame events, one-cycle pulses
	input wire logic RX_PREAMBLE_IN,
	input wire logic RX_ADDR_VALID_IN,
	input wire logic RX_MULTICAST_IN,
	input wire logic RX_BROADCAST_IN,
	input wire logic RX_OWN_ADDR_IN,
	// Flow control actions
	output logic PAUSE_REQ_OUT,
	output logic PAUSE_ZERO_OUT,
	output logic JAM_OUT
);
	import afc_pkg::*;

	logic [31:0] data_q, data_d;
	logic [31:0] cmd_q, cmd_d;
	logic [31:0] cfg_q, cfg_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	xfer_state_type xfer_q, xfer_d;
	logic mac_req_q, mac_req_d;
	logic high_q, high_d;
	logic paused_q, paused_d;
	logic pause_q, pause_d;
	logic zero_q, zero_d;
	logic jam_q, jam_d;
	logic jam_start;
	logic jam_busy;

	logic [7:0] hi_lvl, lo_lvl;
	logic [3:0] dur_code;
	logic any_en, trig_en, at_high, below_low, hit;
	logic wr_acc, rd_acc;

	// Threshold in bytes: units of 64 [RULE16] [RULE4]
	function automatic logic [FIFO_W-1:0] to_bytes(input logic [7:0] lvl);
		return FIFO_W'({lvl, 6'h00});
	endfunction

	// Register select; one decode serves reads, writes and the error flag
	typedef enum {SEL_DATA, SEL_CMD, SEL_CFG, SEL_NONE} reg_sel_type;

	function automatic reg_sel_type decode(input logic [7:0] addr);
		reg_sel_type s;
		s = SEL_NONE;
		case (addr)
			DATA_ADDR: s = SEL_DATA;
			CMD_ADDR: s = SEL_CMD;
			CFG_ADDR: s = SEL_CFG;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction

	reg_sel_type sel;

	assign hi_lvl = cfg_q[HI_LSB +: 8];
	assign lo_lvl = cfg_q[LO_LSB +: 8];
	assign dur_code = cfg_q[DUR_LSB +: 4];
	assign any_en = cfg_q[ANY_BIT];
	assign trig_en = |cfg_q[MULT_BIT:ANY_BIT];
	assign at_high = RX_FIFO_BYTES_IN >= to_bytes(hi_lvl); // [RULE16]
	assign below_low = RX_FIFO_BYTES_IN < to_bytes(lo_lvl); // [RULE7]
	assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN && pready_q;
	assign rd_acc = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
	assign sel = decode(PADDR_IN);

	// APB slave: read data is captured in setup, so the access phase ends at once
	always_comb begin
		prdata_d = prdata_q;
		pready_d = 1'b1;
		pslverr_d = 1'b0;
		if (rd_acc) begin
			case (sel)
				SEL_DATA: prdata_d = data_q;
				SEL_CMD: prdata_d = cmd_q;
				// Reserved bits never held a one, the mask only documents it
				SEL_CFG: prdata_d = cfg_q & CFG_WR_MASK;
				default: prdata_d = '0;
			endcase
		end
		if (PSEL_IN && !PENABLE_IN) begin
			case (sel)
				SEL_NONE: pslverr_d = 1'b1;
				default: pslverr_d = 1'b0;
			endcase
		end
	end

	// Registers and the MAC transfer sequencer
	always_comb begin
		data_d = data_q;
		cmd_d = cmd_q;
		cfg_d = cfg_q;
		xfer_d = xfer_q;
		mac_req_d = mac_req_q;
		if (wr_acc) begin
			case (sel)
				// Host keeps these stable while busy; writes then are dropped [RULE2]
				SEL_DATA: if (!cmd_q[CMD_BUSY_BIT]) data_d = PWDATA_IN; // [RULE1]
				SEL_CMD: if (!cmd_q[CMD_BUSY_BIT]) begin
					cmd_d = PWDATA_IN & CMD_WR_MASK;
					cmd_d[CMD_BUSY_BIT] = PWDATA_IN[CMD_BUSY_BIT]; // [RULE2]
				end
				SEL_CFG: cfg_d = PWDATA_IN & CFG_WR_MASK;
				default: cfg_d = cfg_q;
			endcase
		end
		case (xfer_q)
			IDLE_S: begin
				if (cmd_q[CMD_BUSY_BIT]) begin
					xfer_d = XFER_S;
					mac_req_d = 1'b1; // [RULE2]
				end
			end
			XFER_S: begin
				if (MAC_ACK_IN) begin
					mac_req_d = 1'b0;
					xfer_d = IDLE_S;
					cmd_d[CMD_BUSY_BIT] = 1'b0; // [RULE2]
					if (cmd_q[CMD_READ_BIT]) data_d = MAC_RDATA_IN; // [RULE1]
				end
			end
			default: begin
				xfer_d = IDLE_S;
				mac_req_d = 1'b0;
			end
		endcase
	end

	// Flow control engine
	always_comb begin
		high_d = high_q;
		paused_d = paused_q;
		pause_d = 1'b0;
		zero_d = 1'b0;
		jam_start = 1'b0;
		hit = 1'b0;
		if (any_en) begin
			hit = RX_PREAMBLE_IN; // [RULE15]
		end else begin
			hit = RX_ADDR_VALID_IN && ((cfg_q[MULT_BIT] && RX_MULTICAST_IN) // [RULE12]
				|| (cfg_q[BRD_BIT] && RX_BROADCAST_IN) // [RULE13]
				|| (cfg_q[ADD_BIT] && RX_OWN_ADDR_IN)); // [RULE14]
		end
		if (!trig_en) begin
			high_d = 1'b0;
			paused_d = 1'b0;
		end else if (high_q && below_low) begin
			high_d = 1'b0; // [RULE16]
			paused_d = 1'b0;
			// Zero pause only if a real pause went out first [RULE8] [RULE7]
			if (paused_q && FULL_DUPLEX_IN && TX_ENABLED_IN) zero_d = 1'b1; // [RULE3]
		end else if (at_high) begin
			high_d = 1'b1; // [RULE4]
		end
		if (trig_en && high_d && TX_ENABLED_IN) begin // [RULE3]
			if (FULL_DUPLEX_IN) begin
				// Full duplex acts only for the any-frame bit, once per episode [RULE5] [RULE15]
				if (any_en && !paused_q) begin
					pause_d = 1'b1;
					paused_d = 1'b1;
				end
			end else if (hit) begin
				jam_start = 1'b1; // [RULE6]
			end
		end
	end

	// Jam drops at once if the transmitter stops or duplex changes [RULE3] [RULE10]
	always_comb begin
		jam_d = jam_busy && TX_ENABLED_IN && !FULL_DUPLEX_IN;
	end

	// APB response
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Host registers and transfer sequencer
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			data_q <= DATA_RESET;
			cmd_q <= CMD_RESET;
			cfg_q <= CFG_RESET;
			xfer_q <= IDLE_S;
			mac_req_q <= 1'b0;
		end else begin
			data_q <= data_d;
			cmd_q <= cmd_d;
			cfg_q <= cfg_d;
			xfer_q <= xfer_d;
			mac_req_q <= mac_req_d;
		end
	end

	// Flow control state and action pulses
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			high_q <= 1'b0;
			paused_q <= 1'b0;
			pause_q <= 1'b0;
			zero_q <= 1'b0;
		end else begin
			high_q <= high_d;
			paused_q <= paused_d;
			pause_q <= pause_d;
			zero_q <= zero_d;
		end
	end

	// Back-pressure output
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			jam_q <= 1'b0;
		end else begin
			jam_q <= jam_d;
		end
	end

	jam_timer timer_u (
		.clk_in(SYS_CLK_IN),
		.rst_in(RST_IN),
		.start_in(jam_start),
		.code_in(dur_code),
		.slow_in(SPEED_10_IN),
		.busy_out(jam_busy)
	);

	assign PRDATA_OUT = prdata_q;
	assign PREADY_OUT = pready_q;
	assign PSLVERR_OUT = pslverr_q;
	assign MAC_REQ_OUT = mac_req_q;
	assign MAC_READ_OUT = cmd_q[CMD_READ_BIT];
	assign MAC_ADDR_OUT = cmd_q[7:0];
	assign MAC_WDATA_OUT = data_q;
	assign PAUSE_REQ_OUT = pause_q;
	assign PAUSE_ZERO_OUT = zero_q;
	assign JAM_OUT = jam_q;
endmodule
`default_nettype wire

// ==== tb/rx_flow_ctrl_props.sv ====
// Purpose: Port assertions for rx_flow_ctrl
// Assumes: Config is shadowed from APB writes
// Notes: Bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module rx_flow_ctrl_props (
	// Clock, reset, APB
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	// MAC port and flow
	input wire logic MAC_REQ_OUT,
	input wire logic MAC_ACK_IN,
	input wire logic TX_ENABLED_IN,
	input wire logic FULL_DUPLEX_IN,
	input wire logic [afc_pkg::FIFO_W-1:0] RX_FIFO_BYTES_IN,
	input wire logic PAUSE_REQ_OUT,
	input wire logic PAUSE_ZERO_OUT,
	input wire logic JAM_OUT
);
	import afc_pkg::*;
	logic [31:0] cfg_d, cfg_q;
	logic sent_d, sent_q, wr, hi, lo;
	always_comb begin
		wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
		cfg_d = (wr && PADDR_IN == CFG_ADDR) ? PWDATA_IN : cfg_q;
		sent_d = PAUSE_REQ_OUT || (sent_q && !PAUSE_ZERO_OUT);
		hi = RX_FIFO_BYTES_IN >= {1'b0, cfg_q[23:16], 6'h00};
		lo = RX_FIFO_BYTES_IN < {1'b0, cfg_q[15:8], 6'h00};
	end
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cfg_q <= CFG_RESET;
			sent_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			sent_q <= sent_d;
		end
	end
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);
	a_quiet_tx_off: assert property ($past(!TX_ENABLED_IN) |->
		!PAUSE_REQ_OUT && !PAUSE_ZERO_OUT) else $error("pause with tx off");
	a_single_pause: assert property (
		PAUSE_REQ_OUT |=> !PAUSE_REQ_OUT) else $error("pause twice");
	a_pause_cause: assert property (
		PAUSE_REQ_OUT |-> $past(FULL_DUPLEX_IN && cfg_q[ANY_BIT] && hi)) else $error("bad pause");
	a_zero_cause: assert property (
		PAUSE_ZERO_OUT |-> $past(lo) && sent_q) else $error("bad zero pause");
	a_req_hold: assert property (
		MAC_REQ_OUT && !MAC_ACK_IN |=> MAC_REQ_OUT) else $error("req dropped");
	a_req_done: assert property (
		MAC_REQ_OUT && MAC_ACK_IN |=> !MAC_REQ_OUT) else $error("req stuck");
	a_req_start: assert property (wr && PADDR_IN == CMD_ADDR && PWDATA_IN[CMD_BUSY_BIT]
		&& !MAC_REQ_OUT |-> ##[1:2] MAC_REQ_OUT) else $error("req late");
	a_jam_half: assert property (
		$rose(JAM_OUT) |-> !$past(FULL_DUPLEX_IN, 2)) else $error("jam in full duplex");
	c_pause: cover property (PAUSE_REQ_OUT);
	c_zero: cover property (PAUSE_ZERO_OUT);
	c_jam: cover property ($rose(JAM_OUT));
endmodule
bind rx_flow_ctrl rx_flow_ctrl_props u_props (.SYS_CLK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN,
	.PWRITE_IN, .PADDR_IN, .PWDATA_IN, .MAC_REQ_OUT, .MAC_ACK_IN, .TX_ENABLED_IN,
	.FULL_DUPLEX_IN, .RX_FIFO_BYTES_IN, .PAUSE_REQ_OUT, .PAUSE_ZERO_OUT, .JAM_OUT);
`default_nettype wire

// ==== tb/mac_reg_model.sv ====
// Purpose: Internal MAC register space seen from the transfer port
// Assumes: Request level is held until acknowledged
// Notes: Idle read data toggles so stale values never pass
`timescale 1ns/10ps
`default_nettype none
module mac_reg_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic read_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] delay_in,
	output logic ack_out,
	output logic [31:0] rdata_out
);
	logic [31:0] mem [256];
	logic [3:0] cnt;
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= 4'h0;
			ack_out <= 1'b0;
			rdata_out <= 32'h0;
		end else if (req_in && !ack_out && cnt == delay_in) begin
			ack_out <= 1'b1;
			cnt <= 4'h0;
			if (read_in) rdata_out <= mem[addr_in];
			else mem[addr_in] <= wdata_in;
		end else begin
			ack_out <= 1'b0;
			rdata_out <= ~rdata_out;
			cnt <= (req_in && !ack_out) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// ==== tb/rx_flow_ctrl_tb.sv ====
// Purpose: Self-checking bench for rx_flow_ctrl
// Assumes: Zero-wait APB slave, one clock
// Notes: Jam lengths are checked cycle for cycle at full length
`timescale 1ns/10ps
`default_nettype none
module rx_flow_ctrl_tb;
	import afc_pkg::*;
	logic SYS_CLK_IN = 0, RST_IN = 1, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
	logic TX_ENABLED_IN = 1, FULL_DUPLEX_IN = 1, SPEED_10_IN = 0, RX_PREAMBLE_IN = 0;
	logic RX_ADDR_VALID_IN = 0, RX_MULTICAST_IN = 0, RX_BROADCAST_IN = 0, RX_OWN_ADDR_IN = 0;
	logic PREADY_OUT, PSLVERR_OUT, MAC_REQ_OUT, MAC_READ_OUT, MAC_ACK_IN, err;
	logic PAUSE_REQ_OUT, PAUSE_ZERO_OUT, JAM_OUT;
	logic [7:0] PADDR_IN = 0, MAC_ADDR_OUT;
	logic [31:0] PWDATA_IN = 0, PRDATA_OUT, MAC_WDATA_OUT, MAC_RDATA_IN, rd;
	logic [FIFO_W-1:0] RX_FIFO_BYTES_IN = 0;
	logic [3:0] dly = 0;
	logic [3:0] hit [4] = '{4'h8, 4'h1, 4'h2, 4'h4};
	logic [3:0] miss [4] = '{4'h0, 4'h2, 4'h4, 4'h1};
	int cyc [4] = '{1000, 2000, 3000, 5000};
	int miscompares = 0, check_count = 0, pq = 0, zq = 0, n;
	rx_flow_ctrl dut (.SYS_CLK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN,
		.PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .MAC_REQ_OUT, .MAC_READ_OUT,
		.MAC_ADDR_OUT, .MAC_WDATA_OUT, .MAC_ACK_IN, .MAC_RDATA_IN, .TX_ENABLED_IN,
		.FULL_DUPLEX_IN, .SPEED_10_IN, .RX_FIFO_BYTES_IN, .RX_PREAMBLE_IN, .RX_ADDR_VALID_IN,
		.RX_MULTICAST_IN, .RX_BROADCAST_IN, .RX_OWN_ADDR_IN, .PAUSE_REQ_OUT,
		.PAUSE_ZERO_OUT, .JAM_OUT);
	mac_reg_model u_mac (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .req_in(MAC_REQ_OUT),
		.read_in(MAC_READ_OUT), .addr_in(MAC_ADDR_OUT), .wdata_in(MAC_WDATA_OUT),
		.delay_in(dly), .ack_out(MAC_ACK_IN), .rdata_out(MAC_RDATA_IN));
	always #2.5 SYS_CLK_IN = ~SYS_CLK_IN;
	always @(posedge SYS_CLK_IN) begin
		pq <= pq + PAUSE_REQ_OUT;
		zq <= zq + PAUSE_ZERO_OUT;
	end
	task give_verdict;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		PSEL_IN <= 1;
		PWRITE_IN <= w;
		PADDR_IN <= a;
		PWDATA_IN <= d;
		@(posedge SYS_CLK_IN);
		PENABLE_IN <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge SYS_CLK_IN);
			if (PREADY_OUT === 1'b1) break;
		end
		rd = PRDATA_OUT;
		err = PSLVERR_OUT;
		PSEL_IN <= 0;
		PENABLE_IN <= 0;
		if (i == 50) chk("pready", 1, 0);
		if (i == 50) give_verdict;
		@(posedge SYS_CLK_IN);
	endtask
	task frame(input logic [3:0] e, input int exp);
		int i, len;
		{RX_PREAMBLE_IN, RX_MULTICAST_IN, RX_BROADCAST_IN, RX_OWN_ADDR_IN} <= e;
		RX_ADDR_VALID_IN <= |e[2:0];
		@(posedge SYS_CLK_IN);
		{RX_PREAMBLE_IN, RX_MULTICAST_IN, RX_BROADCAST_IN, RX_OWN_ADDR_IN} <= 4'h0;
		RX_ADDR_VALID_IN <= 0;
		len = 0;
		for (i = 0; i < 4 && JAM_OUT !== 1'b1; i++) @(posedge SYS_CLK_IN);
		for (i = 0; i < 6000 && JAM_OUT === 1'b1; i++) begin
			@(posedge SYS_CLK_IN);
			len++;
		end
		chk("jam length", exp, len);
	endtask
	initial begin
		repeat (8) @(posedge SYS_CLK_IN);
		RST_IN <= 0;
		@(posedge SYS_CLK_IN);
		apb(0, DATA_ADDR, 0);
		chk("data reset", DATA_RESET, rd);
		apb(0, 8'hB0, 0);
		chk("unmapped", 32'h1, {rd[30:0], err});
		apb(1, CFG_ADDR, 32'hFFFF_7EFF);
		apb(0, CFG_ADDR, 0);
		chk("config", 32'h00FF_7EFF, rd);
		chk("zero unpaused", 0, zq);
		$display("test registers done");
		dly <= 4'h6;
		apb(1, DATA_ADDR, 32'h1234_5678);
		apb(1, CMD_ADDR, 32'h8000_0012);
		apb(1, DATA_ADDR, 32'hDEAD_BEEF);
		apb(0, CMD_ADDR, 0);
		chk("busy held", 32'h8000_0012, rd);
		for (n = 0; n < 20 && rd[31] !== 1'b0; n++) apb(0, CMD_ADDR, 0);
		chk("busy clear", 0, rd[31]);
		chk("mac write", 32'h1234_5678, u_mac.mem[8'h12]);
		apb(1, DATA_ADDR, 32'h0);
		dly <= 4'h0;
		apb(1, CMD_ADDR, 32'hC000_0012);
		apb(0, CMD_ADDR, 0);
		chk("read busy held", 32'hC000_0012, rd);
		for (n = 0; n < 20 && rd[31] !== 1'b0; n++) apb(0, CMD_ADDR, 0);
		chk("read busy clear", 0, rd[31]);
		apb(0, DATA_ADDR, 0);
		chk("mac read", 32'h1234_5678, rd);
		$display("test mac transfer done");
		apb(1, CFG_ADDR, 32'h0002_010E);
		n = pq;
		RX_FIFO_BYTES_IN <= 15'd200;
		frame(4'h7, 0);
		chk("pause no any", 0, pq - n);
		RX_FIFO_BYTES_IN <= 15'd0;
		apb(1, CFG_ADDR, 32'h0002_0101);
		RX_FIFO_BYTES_IN <= 15'd128;
		repeat (20) @(posedge SYS_CLK_IN);
		chk("pause once", 1, pq - n);
		n = zq;
		RX_FIFO_BYTES_IN <= 15'd64;
		repeat (10) @(posedge SYS_CLK_IN);
		chk("zero at low", 0, zq - n);
		RX_FIFO_BYTES_IN <= 15'd63;
		repeat (10) @(posedge SYS_CLK_IN);
		chk("zero pause", 1, zq - n);
		TX_ENABLED_IN <= 0;
		n = pq;
		RX_FIFO_BYTES_IN <= 15'd200;
		repeat (10) @(posedge SYS_CLK_IN);
		chk("pause tx off", 0, pq - n);
		$display("test full duplex done");
		FULL_DUPLEX_IN <= 0;
		frame(4'h8, 0);
		TX_ENABLED_IN <= 1;
		for (int b = 0; b < 4; b++) begin
			apb(1, CFG_ADDR, 32'h0002_0100 | (b << 4) | (1 << b));
			SPEED_10_IN <= b[0];
			frame(miss[b], 0);
			frame(hit[b], cyc[b] + 440 * b[0]);
		end
		$display("test half duplex done");
		give_verdict;
	end
endmodule
`default_nettype wire
